// ---- p9ps_pkg.sv ----
package p9ps_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned         ADDR_W                 = 12;
    localparam logic [11:0]         FUNC_SEL_IDX           = 12'h3b7;
    localparam logic [11:0]         FUNC_SEL_ADDR          = 12'hedc;
    localparam logic [11:0]         PORT_SEL_ADDR          = 12'hee0;
    localparam logic [7:0]          FUNC_SEL_RST           = 8'h00;
    localparam logic [7:0]          FUNC_SEL_WMASK         = 8'hfa;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned         PIN91_SRC_BIT          = 1;
    localparam int unsigned         PIN93_DIS_BIT          = 3;
    localparam int unsigned         PIN94_DIS_BIT          = 4;
    localparam int unsigned         PIN95_DIS_BIT          = 5;
    localparam int unsigned         PIN96_DIS_BIT          = 6;
    localparam int unsigned         PIN97_SRC_BIT          = 7;
    localparam int unsigned         PORT_SEL_P91_BIT       = 0;
    localparam int unsigned         PORT_SEL_P97_BIT       = 1;
    localparam logic [1:0]          PORT_SEL_RST           = 2'h0;

endpackage

// ---- p9ps_out_mux.sv ----
`timescale 1ns/1ps

// Output source selection for one serial channel pin.
module p9ps_out_mux (
    input  wire logic i_port_fn,         // 1: peripheral output, 0: general I/O.
    input  wire logic i_src_sel,         // 0: serial clock, 1: special transmit data.
    input  wire logic i_sclk,            // Serial clock output of the channel.
    input  wire logic i_stx,             // Special-mode transmit data of the channel.
    input  wire logic i_gpio,            // General-purpose port output level.
    output logic      o_pin              // Level driven toward the pin.
);

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    // The source choice only matters while the port gives the pin away.
    always_comb begin
        if (i_port_fn) begin
            o_pin = i_src_sel ? i_stx : i_sclk;
        end else begin
            o_pin = i_gpio;
        end
    end

endmodule

// ---- p9ps_top.sv ----
`timescale 1ns/1ps

// Contract
// - Pin 91 bit 0 routes channel 3 clock, 1 routes channel 3 special transmit.
// - Pin 97 bit 0 routes channel 4 clock, 1 routes channel 4 special transmit.
// - Pins 93/94 bit 1 cuts input functions, pin serves as DAC output 0/1.
// - Pins 95/96 bit 1 cuts input functions, pin serves as extended analog input.
// - Bits 0 and 2 unused; write zero, reads undefined (here zero).
module p9ps_top
    import p9ps_pkg::*;
(
    input  wire logic                 I_SYS_CLK,          // System clock, 40 MHz.
    input  wire logic                 I_SYS_RST,          // Asynchronous reset, active high.
    input  wire logic                 I_PSEL,             // APB select.
    input  wire logic                 I_PENABLE,          // APB access phase.
    input  wire logic                 I_PWRITE,           // APB write direction.
    input  wire logic [p9ps_pkg::ADDR_W-1:0] I_PADDR,     // APB byte address.
    input  wire logic [31:0]          I_PWDATA,           // APB write data.
    output logic      [31:0]          O_PRDATA,           // APB read data.
    output logic                      O_PREADY,           // APB ready.
    output logic                      O_PSLVERR,          // APB error on unmapped address.
    input  wire logic                 I_CH3_SCLK,         // Channel 3 serial clock output.
    input  wire logic                 I_CH3_STX,          // Channel 3 special transmit data.
    input  wire logic                 I_CH4_SCLK,         // Channel 4 serial clock output.
    input  wire logic                 I_CH4_STX,          // Channel 4 special transmit data.
    input  wire logic                 I_P91_GPIO,         // Port output level for pin 91.
    input  wire logic                 I_P97_GPIO,         // Port output level for pin 97.
    input  wire logic [3:0]           I_PIN_IN,           // Pin levels of pins 93 to 96.
    output logic                      O_PIN91_OUT,        // Level driven toward pin 91.
    output logic                      O_PIN97_OUT,        // Level driven toward pin 97.
    output logic [3:0]                O_PERIPH_IN,        // Pin levels seen by input peripherals.
    output logic                      O_DAC_OUT_0_EN,     // Pin 93 given to DAC output 0.
    output logic                      O_DAC_OUT_1_EN,     // Pin 94 given to DAC output 1.
    output logic                      O_EXT_ANALOG_IN_0_EN, // Pin 95 given to analog input 0.
    output logic                      O_EXT_ANALOG_IN_1_EN  // Pin 96 given to analog input 1.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]  func_sel_ff;
    logic [7:0]  nxt_func_sel;
    logic [1:0]  port_sel_ff;
    logic [1:0]  nxt_port_sel;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic        access;
    logic        hit_func;
    logic        hit_port;

    // Address decode, shared by the write and read paths.
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        return a == r;
    endfunction

    // Decode of the access phase; the slave answers with no wait state.
    always_comb begin
        access   = I_PSEL && I_PENABLE;
        hit_func = addr_is(I_PADDR, FUNC_SEL_ADDR);
        hit_port = addr_is(I_PADDR, PORT_SEL_ADDR);
    end

    // Ready and error are combinational handshake outputs.
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = access && !hit_func && !hit_port;
    assign O_PRDATA  = prdata_ff;

    // ------------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------------
    // Unused bits 0 and 2 are never stored, so they read back as zero.
    always_comb begin
        nxt_func_sel = func_sel_ff;
        nxt_port_sel = port_sel_ff;
        nxt_prdata   = prdata_ff;
        if (access && I_PWRITE && hit_func) begin
            nxt_func_sel = I_PWDATA[7:0] & FUNC_SEL_WMASK;
        end
        if (access && I_PWRITE && hit_port) begin
            nxt_port_sel = I_PWDATA[1:0];
        end
        if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            if (hit_func) begin
                nxt_prdata = {24'h000000, func_sel_ff};
            end else if (hit_port) begin
                nxt_prdata = {30'h00000000, port_sel_ff};
            end else begin
                nxt_prdata = 32'h00000000;
            end
        end
    end

    // Registers.
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            func_sel_ff <= FUNC_SEL_RST;
            port_sel_ff <= PORT_SEL_RST;
            prdata_ff   <= 32'h00000000;
        end else begin
            func_sel_ff <= nxt_func_sel;
            port_sel_ff <= nxt_port_sel;
            prdata_ff   <= nxt_prdata;
        end
    end

    // ------------------------------------------------------------------
    // Serial channel pins
    // ------------------------------------------------------------------
    // Pin 91 carries channel 3, pin 97 carries channel 4.
    p9ps_out_mux u_mux91 (
        .i_port_fn (port_sel_ff[PORT_SEL_P91_BIT]),
        .i_src_sel (func_sel_ff[PIN91_SRC_BIT]),
        .i_sclk    (I_CH3_SCLK),
        .i_stx     (I_CH3_STX),
        .i_gpio    (I_P91_GPIO),
        .o_pin     (O_PIN91_OUT)
    );

    p9ps_out_mux u_mux97 (
        .i_port_fn (port_sel_ff[PORT_SEL_P97_BIT]),
        .i_src_sel (func_sel_ff[PIN97_SRC_BIT]),
        .i_sclk    (I_CH4_SCLK),
        .i_stx     (I_CH4_STX),
        .i_gpio    (I_P97_GPIO),
        .o_pin     (O_PIN97_OUT)
    );

    // ------------------------------------------------------------------
    // Analog pins
    // ------------------------------------------------------------------
    // A set bit hands the pin to the analog block and holds input peripherals low.
    always_comb begin
        O_DAC_OUT_0_EN       = func_sel_ff[PIN93_DIS_BIT];
        O_DAC_OUT_1_EN       = func_sel_ff[PIN94_DIS_BIT];
        O_EXT_ANALOG_IN_0_EN = func_sel_ff[PIN95_DIS_BIT];
        O_EXT_ANALOG_IN_1_EN = func_sel_ff[PIN96_DIS_BIT];
        O_PERIPH_IN[0] = I_PIN_IN[0] && !func_sel_ff[PIN93_DIS_BIT];
        O_PERIPH_IN[1] = I_PIN_IN[1] && !func_sel_ff[PIN94_DIS_BIT];
        O_PERIPH_IN[2] = I_PIN_IN[2] && !func_sel_ff[PIN95_DIS_BIT];
        O_PERIPH_IN[3] = I_PIN_IN[3] && !func_sel_ff[PIN96_DIS_BIT];
    end

endmodule

// ---- p9ps_chk.sv ----
`timescale 1ns/1ps
// Watches the port 9 select block from its ports.
module p9ps_chk
    import p9ps_pkg::*;
(
    input wire logic              I_SYS_CLK,            // System clock.
    input wire logic              I_SYS_RST,            // Reset, active high.
    input wire logic              I_PSEL,               // Bus select.
    input wire logic              I_PENABLE,            // Bus access phase.
    input wire logic              I_PWRITE,             // Bus direction.
    input wire logic [ADDR_W-1:0] I_PADDR,              // Bus address.
    input wire logic [31:0]       I_PWDATA,             // Bus write data.
    input wire logic [31:0]       O_PRDATA,             // Bus read data.
    input wire logic              I_CH3_SCLK,           // Channel 3 clock source.
    input wire logic              I_CH3_STX,            // Channel 3 transmit source.
    input wire logic              I_CH4_SCLK,           // Channel 4 clock source.
    input wire logic              I_CH4_STX,            // Channel 4 transmit source.
    input wire logic              I_P91_GPIO,           // Port level for pin 91.
    input wire logic              I_P97_GPIO,           // Port level for pin 97.
    input wire logic              O_PIN91_OUT,          // Level toward pin 91.
    input wire logic              O_PIN97_OUT,          // Level toward pin 97.
    input wire logic [3:0]        I_PIN_IN,             // Levels of pins 93 to 96.
    input wire logic [3:0]        O_PERIPH_IN,          // Levels seen by input peripherals.
    input wire logic              O_DAC_OUT_0_EN,       // Pin 93 given to DAC output 0.
    input wire logic              O_DAC_OUT_1_EN,       // Pin 94 given to DAC output 1.
    input wire logic              O_EXT_ANALOG_IN_0_EN, // Pin 95 given to analog input 0.
    input wire logic              O_EXT_ANALOG_IN_1_EN  // Pin 96 given to analog input 1.
);
    logic [3:0] shd_ff; // Source 91, source 97, port 91, port 97.
    logic [3:0] nxt_shd;
    logic       wr_acc;
    // Shadow of the routing bits, loaded by completed writes.
    always_comb begin
        wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
        nxt_shd = shd_ff;
        if (wr_acc && I_PADDR == FUNC_SEL_ADDR) nxt_shd[1:0] = {I_PWDATA[7], I_PWDATA[1]};
        if (wr_acc && I_PADDR == PORT_SEL_ADDR) nxt_shd[3:2] = I_PWDATA[1:0];
    end
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) shd_ff <= 4'h0;
        else shd_ff <= nxt_shd;
    end
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_pin91_route: assert property (
        O_PIN91_OUT == (shd_ff[2] ? (shd_ff[0] ? I_CH3_STX : I_CH3_SCLK) : I_P91_GPIO))
        else $error("Pin 91 level wrong.");
    a_pin97_route: assert property (
        O_PIN97_OUT == (shd_ff[3] ? (shd_ff[1] ? I_CH4_STX : I_CH4_SCLK) : I_P97_GPIO))
        else $error("Pin 97 level wrong.");
    a_dac_write: assert property (wr_acc && I_PADDR == FUNC_SEL_ADDR |=>
        {O_DAC_OUT_1_EN, O_DAC_OUT_0_EN} == $past(I_PWDATA[4:3])) else $error("DAC enable wrong.");
    a_dac_gate: assert property (
        O_PERIPH_IN[1:0] == (I_PIN_IN[1:0] & ~{O_DAC_OUT_1_EN, O_DAC_OUT_0_EN}))
        else $error("Pin 93/94 input wrong.");
    a_anex_write: assert property (wr_acc && I_PADDR == FUNC_SEL_ADDR |=>
        {O_EXT_ANALOG_IN_1_EN, O_EXT_ANALOG_IN_0_EN} == $past(I_PWDATA[6:5]))
        else $error("Analog enable wrong.");
    a_anex_gate: assert property (
        O_PERIPH_IN[3:2] == (I_PIN_IN[3:2] & ~{O_EXT_ANALOG_IN_1_EN, O_EXT_ANALOG_IN_0_EN}))
        else $error("Pin 95/96 input wrong.");
    a_unused_read: assert property (I_PSEL && I_PENABLE && !I_PWRITE &&
        I_PADDR == FUNC_SEL_ADDR |-> O_PRDATA[2] == 1'b0 && O_PRDATA[0] == 1'b0)
        else $error("Unused bits not zero.");
endmodule
bind p9ps_top p9ps_chk i_chk (.*);

// ---- testbench.sv ----
`timescale 1ns/1ps
// Drives the select block over its bus and pins.
module testbench;
    import p9ps_pkg::*;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, e;
    logic pin91, pin97;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] chan = 4'h5, pin_in = 4'hf, periph, en;
    logic [1:0] gpio = 2'h2;
    logic [7:0] vals [4] = '{8'h02, 8'h80, 8'hfa, 8'h00};
    int num_errors = 0, n_tests = 0;
    p9ps_top i_p9ps_top (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CH3_SCLK(chan[0]), .I_CH3_STX(chan[1]),
        .I_CH4_SCLK(chan[2]), .I_CH4_STX(chan[3]), .I_P91_GPIO(gpio[0]), .I_P97_GPIO(gpio[1]),
        .I_PIN_IN(pin_in), .O_PIN91_OUT(pin91), .O_PIN97_OUT(pin97), .O_PERIPH_IN(periph),
        .O_DAC_OUT_0_EN(en[0]), .O_DAC_OUT_1_EN(en[1]), .O_EXT_ANALOG_IN_0_EN(en[2]),
        .O_EXT_ANALOG_IN_1_EN(en[3]));
    // One bus transfer: setup, then access until ready.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d.", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Clock and hang guard.
    initial forever #12.5 clk = ~clk;
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    // Reset, then each select value with both source patterns.
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, FUNC_SEL_ADDR, 32'h0);
        chk("func reset", q, {24'h0, FUNC_SEL_RST});
        apb(1'b1, PORT_SEL_ADDR, 32'h3);
        foreach (vals[i]) begin
            apb(1'b1, FUNC_SEL_ADDR, {24'h0, vals[i]});
            apb(1'b0, FUNC_SEL_ADDR, 32'h0);
            chk("func read", q, {24'h0, vals[i]});
            chk("func error", {31'h0, e}, 32'h0);
            for (int k = 0; k < 2; k++) begin
                @(posedge clk);
                chan <= (k == 0) ? 4'h5 : 4'ha;
                pin_in <= (k == 0) ? 4'hf : 4'h5;
                @(negedge clk);
                chk("pin91", {31'h0, pin91}, {31'h0, vals[i][1] ? chan[1] : chan[0]});
                chk("pin97", {31'h0, pin97}, {31'h0, vals[i][7] ? chan[3] : chan[2]});
                chk("enables", {28'h0, en}, {28'h0, vals[i][6:3]});
                chk("periph in", {28'h0, periph}, {28'h0, pin_in & ~vals[i][6:3]});
            end
        end
        apb(1'b1, PORT_SEL_ADDR, 32'h0);
        gpio <= 2'h3;
        @(negedge clk);
        chk("gpio pins", {30'h0, pin97, pin91}, {30'h0, gpio});
        apb(1'b1, 12'h100, 32'hff);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", {q[30:0], e}, 32'h1);
        apb(1'b0, FUNC_SEL_ADDR, 32'h0);
        chk("func kept", q, 32'h0);
        wrap_up();
    end
endmodule
